// >>> uts_pkg.sv
// Package for the USB termination select block: register map, fields,
// resets and line encodings.
// Assumes a single 250 MHz clock domain and a plain register port.
package uts_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_FUNC_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OTG_CTRL  = 8'h0a;
    localparam logic [7:0] ADDR_HS_COMP   = 8'h31;
    localparam logic [7:0] ADDR_STATUS    = 8'h40;
    // Function control fields
    localparam int FC_XCVR_LSB = 0;
    localparam int FC_TERM_BIT = 2;
    localparam int FC_OPM_LSB  = 3;
    // Bus control fields
    localparam int OC_DPPD_BIT = 1;
    localparam int OC_DMPD_BIT = 2;
    // Compensation fields
    localparam int HC_AMP_LSB  = 0;
    localparam int HC_SQ_LSB   = 4;
    // Reset values
    localparam logic [7:0] FUNC_CTRL_RST = 8'h41;
    localparam logic [7:0] OTG_CTRL_RST  = 8'h06;
    localparam logic [7:0] HS_COMP_RST   = 8'h00;
    // Field encodings
    localparam logic [1:0] XCVR_HS   = 2'h0;
    localparam logic [1:0] XCVR_FS   = 2'h1;
    localparam logic [1:0] XCVR_LS   = 2'h2;
    localparam logic [1:0] OPM_NORM  = 2'h0;
    localparam logic [1:0] OPM_NODRV = 2'h1;
    localparam logic [1:0] OPM_NRZI  = 2'h2;
    // Termination vector order {dp_pu, dm_pu, dp_pd, dm_pd, hs_term}
    localparam logic [4:0] TERM_OFF      = 5'h00;
    localparam logic [4:0] TERM_FALLBACK = 5'h06;
    // Bit stuffing after six ones
    localparam logic [2:0] STUFF_LIMIT = 3'h6;
    // Transmit sequencer states, one-hot
    typedef enum logic [3:0] {
        UTS_TX_IDLE  = 4'h1,
        UTS_TX_DATA  = 4'h2,
        UTS_TX_STUFF = 4'h4,
        UTS_TX_EOP   = 4'h8
    } uts_tx_state_t;
endpackage : uts_pkg

// >>> uts_usb_termination_select.sv
// USB transceiver control: termination decode, rx selection, line state,
// tx encode/stuff/serialize and trim registers.
// Assumes link drives the register port on CLK; line inputs are async.
//
// Contract
// - Non-driving opmode clears all terminations
// - Undefined combinations fall back to pull-downs
// - Host settings enable both pull-downs, plus HS termination in HS
// - HS termination only for HS, termselect zero
// - Peripheral chirp: DP pull-up, optional DM pull-down
// - Peripheral FS: DP pull-up, optional DM pull-down
// - Peripheral LS: DM pull-up only
// - Peripheral HS: HS termination, optional DM pull-down
// - Host FS/LS: both pull-downs only
// - Charger connect detect: DM pull-down only
// - Reset pin low tri-states line drivers
// - Terminations follow mode, no link trimming
// - Encode, stuff, serialize; separate HS, FS transmitters
// - Mode-selected receiver muxed into rx logic
// - HS squelch blocks noise as data
// - Single-ended DP/DM receivers give line state
// - Amplitude trim bits in compensation register
// - Squelch sensitivity bits in compensation register
`timescale 1ns/10ps
module uts_usb_termination_select (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       TX_VALID,
    input  wire logic       TX_BIT,
    output logic            TX_READY,
    input  wire logic       HS_RX_IN,
    input  wire logic       FS_RX_IN,
    input  wire logic       SQUELCH_IN,
    input  wire logic       SE_DP_IN,
    input  wire logic       SE_DM_IN,
    output logic            RX_BIT,
    output logic            RX_VALID,
    output logic      [1:0] LINE_STATE,
    output logic            HS_TX_DATA,
    output logic            HS_TX_OE,
    output logic            FS_TX_DATA,
    output logic            FS_TX_OE,
    output logic            DP_PULLUP_ENABLE,
    output logic            DM_PULLUP_ENABLE,
    output logic            DP_PULLDOWN_ENABLE,
    output logic            DM_PULLDOWN_ENABLE,
    output logic            HS_TERMINATION_ENABLE,
    output logic      [3:0] TX_AMPLITUDE_TRIM,
    output logic      [3:0] SQUELCH_SENSITIVITY_TRIM
);
    // Register storage
    logic [7:0] func_q;
    logic [7:0] otg_q;
    logic [7:0] comp_q;
    logic [7:0] rdata_q;

    // Write decode
    wire wr_func = REG_WR && (REG_ADDR == uts_pkg::ADDR_FUNC_CTRL);
    wire wr_otg  = REG_WR && (REG_ADDR == uts_pkg::ADDR_OTG_CTRL);
    wire wr_comp = REG_WR && (REG_ADDR == uts_pkg::ADDR_HS_COMP);

    // Register writes; reset value puts the line in the power-up state
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            func_q <= uts_pkg::FUNC_CTRL_RST;
            otg_q  <= uts_pkg::OTG_CTRL_RST;
            comp_q <= uts_pkg::HS_COMP_RST;
        end else begin
            if (wr_func) func_q <= REG_WDATA;
            if (wr_otg)  otg_q  <= REG_WDATA;
            if (wr_comp) comp_q <= REG_WDATA;
        end
    end

    // Field extraction
    wire [1:0] xcvr = func_q[uts_pkg::FC_XCVR_LSB +: 2];
    wire       term = func_q[uts_pkg::FC_TERM_BIT];
    wire [1:0] opm  = func_q[uts_pkg::FC_OPM_LSB +: 2];
    wire       dppd = otg_q[uts_pkg::OC_DPPD_BIT];
    wire       dmpd = otg_q[uts_pkg::OC_DMPD_BIT];

    // Trim fields drive the analog front end directly
    assign TX_AMPLITUDE_TRIM        = comp_q[uts_pkg::HC_AMP_LSB +: 4];
    assign SQUELCH_SENSITIVITY_TRIM = comp_q[uts_pkg::HC_SQ_LSB +: 4];

    // Condition decode for the defined table entries
    wire opm_ok   = (opm == uts_pkg::OPM_NORM) || (opm == uts_pkg::OPM_NRZI);
    wire is_host  = dppd && dmpd;
    wire is_peri  = !dppd;
    wire hs_sel   = (xcvr == uts_pkg::XCVR_HS) && !term;
    wire chirp_pe = (xcvr == uts_pkg::XCVR_HS) && term
                    && (opm == uts_pkg::OPM_NRZI);
    wire fs_pe    = (xcvr == uts_pkg::XCVR_FS) && term;
    wire ls_pe    = (xcvr == uts_pkg::XCVR_LS) && term;
    wire host_fsl = term && (xcvr != uts_pkg::XCVR_HS) && opm_ok;
    wire pwr_up   = (xcvr == uts_pkg::XCVR_FS) && !term
                    && (opm == uts_pkg::OPM_NORM);
    wire chg_det  = pwr_up && !dppd && dmpd;

    // Termination vector {dp_pu, dm_pu, dp_pd, dm_pd, hs_term}
    logic [4:0] term_vec;

    // Pure decode so a register write shows up in the same cycle after it
    always_comb begin
        term_vec = uts_pkg::TERM_FALLBACK;
        if (opm == uts_pkg::OPM_NODRV) begin
            term_vec = uts_pkg::TERM_OFF;
        end else if (is_host && hs_sel && opm_ok) begin
            term_vec = 5'h07;
        end else if (is_host && (host_fsl || pwr_up)) begin
            term_vec = 5'h06;
        end else if (is_peri && chirp_pe) begin
            term_vec = {1'b1, 1'b0, 1'b0, dmpd, 1'b0};
        end else if (is_peri && hs_sel && opm_ok) begin
            term_vec = {1'b0, 1'b0, 1'b0, dmpd, 1'b1};
        end else if (is_peri && fs_pe && opm_ok) begin
            term_vec = {1'b1, 1'b0, 1'b0, dmpd, 1'b0};
        end else if (is_peri && !dmpd && ls_pe && opm_ok) begin
            term_vec = 5'h08;
        end else if (chg_det) begin
            term_vec = 5'h02;
        end
    end

    assign DP_PULLUP_ENABLE      = term_vec[4];
    assign DM_PULLUP_ENABLE      = term_vec[3];
    assign DP_PULLDOWN_ENABLE    = term_vec[2];
    assign DM_PULLDOWN_ENABLE    = term_vec[1];
    assign HS_TERMINATION_ENABLE = term_vec[0];

    // Read decode; unmapped addresses read zero
    wire [7:0] rd_mux =
        (REG_ADDR == uts_pkg::ADDR_FUNC_CTRL) ? func_q :
        (REG_ADDR == uts_pkg::ADDR_OTG_CTRL)  ? otg_q  :
        (REG_ADDR == uts_pkg::ADDR_HS_COMP)   ? comp_q :
        (REG_ADDR == uts_pkg::ADDR_STATUS)    ?
            {1'b0, term_vec, LINE_STATE} : 8'h00;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RESET_N) rdata_q <= 8'h00;
        else          rdata_q <= REG_RD ? rd_mux : 8'h00;
    end
    assign REG_RDATA = rdata_q;

    // Three-stage synchronisers for the async receiver inputs
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic [4:0] s3_q;
    logic [4:0] stab_q;
    wire  [4:0] raw = {HS_RX_IN, FS_RX_IN, SQUELCH_IN, SE_DP_IN, SE_DM_IN};

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Take a change only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_stab
            always_ff @(posedge CLK) begin
                if (!RESET_N)                  stab_q[gi] <= 1'b0;
                else if (s2_q[gi] == s3_q[gi]) stab_q[gi] <= s3_q[gi];
            end
        end
    endgenerate

    wire hs_rx  = stab_q[4];
    wire fs_rx  = stab_q[3];
    wire sq_on  = stab_q[2];
    wire hs_mode = (xcvr == uts_pkg::XCVR_HS);

    // Receive path registered; squelch clears RX_VALID for HS data, RX_BIT still follows
    logic rx_bit_q;
    logic rx_val_q;
    logic [1:0] ls_q;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            rx_bit_q <= 1'b0;
            rx_val_q <= 1'b0;
            ls_q     <= 2'h0;
        end else begin
            rx_bit_q <= hs_mode ? hs_rx : fs_rx;
            rx_val_q <= hs_mode ? !sq_on : 1'b1;
            ls_q     <= {stab_q[0], stab_q[1]};
        end
    end
    assign RX_BIT     = rx_bit_q;
    assign RX_VALID   = rx_val_q;
    assign LINE_STATE = ls_q;

    // Transmit: NRZI encode with bit stuffing
    uts_pkg::uts_tx_state_t st_q;
    uts_pkg::uts_tx_state_t st_d;
    logic [2:0] ones_q;
    logic       nrzi_q;
    logic       oe_q;
    wire  stuff_now = (ones_q == uts_pkg::STUFF_LIMIT);
    wire  take      = TX_VALID && TX_READY;
    // Sixth one in a row: the next slot carries the stuffed zero
    wire  stuff_nxt = take && TX_BIT
                      && (ones_q == uts_pkg::STUFF_LIMIT - 3'h1);
    assign TX_READY = (st_q == uts_pkg::UTS_TX_IDLE
                       || st_q == uts_pkg::UTS_TX_DATA) && !stuff_now;

    // Next state: stuff stalls the source for one bit time
    always_comb begin
        case (st_q)
            uts_pkg::UTS_TX_IDLE:
                st_d = TX_VALID ? uts_pkg::UTS_TX_DATA : uts_pkg::UTS_TX_IDLE;
            uts_pkg::UTS_TX_DATA:
                st_d = stuff_nxt ? uts_pkg::UTS_TX_STUFF :
                       TX_VALID  ? uts_pkg::UTS_TX_DATA  : uts_pkg::UTS_TX_EOP;
            uts_pkg::UTS_TX_STUFF:
                st_d = uts_pkg::UTS_TX_DATA;
            uts_pkg::UTS_TX_EOP:
                st_d = uts_pkg::UTS_TX_IDLE;
            default:
                st_d = uts_pkg::UTS_TX_IDLE;
        endcase
    end

    // Serializer: a zero toggles the line, a one holds it
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_q   <= uts_pkg::UTS_TX_IDLE;
            ones_q <= 3'h0;
            nrzi_q <= 1'b1;
            oe_q   <= 1'b0;
        end else begin
            st_q <= st_d;
            if (stuff_now) begin
                nrzi_q <= !nrzi_q;
                ones_q <= 3'h0;
            end else if (take) begin
                nrzi_q <= TX_BIT ? nrzi_q : !nrzi_q;
                ones_q <= TX_BIT ? ones_q + 3'h1 : 3'h0;
            end else if (st_q == uts_pkg::UTS_TX_EOP) begin
                ones_q <= 3'h0; // Stale run must not stuff the next packet
            end
            oe_q <= take || stuff_now;
        end
    end

    // Separate HS and FS/LS drivers; both released while in reset
    wire drive_ok = RESET_N && (opm != uts_pkg::OPM_NODRV);
    assign HS_TX_DATA = nrzi_q;
    assign FS_TX_DATA = nrzi_q;
    assign HS_TX_OE   = oe_q && drive_ok && hs_mode;
    assign FS_TX_OE   = oe_q && drive_ok && !hs_mode;

    // Checks: terminations against the decode table
    // Non-driving mode must win over every other field
    a_nodrv_all_off: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (opm == uts_pkg::OPM_NODRV) |-> (term_vec == uts_pkg::TERM_OFF))
        else $error("terminations not cleared in non-driving mode");
    a_nodrv_no_oe: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (opm == uts_pkg::OPM_NODRV) |-> (!HS_TX_OE && !FS_TX_OE))
        else $error("driver enabled in non-driving mode");

    // Opmode 11 is in no table row, so it must land on the fallback
    a_undef_fallback: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (opm == 2'h3) |-> (term_vec == uts_pkg::TERM_FALLBACK))
        else $error("undefined setting not on fallback");

    // Host side: never a pull-up, both pull-downs outside non-driving mode
    a_host_pulldowns: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (is_host && opm != uts_pkg::OPM_NODRV)
        |-> (DP_PULLDOWN_ENABLE && DM_PULLDOWN_ENABLE
             && !DP_PULLUP_ENABLE && !DM_PULLUP_ENABLE))
        else $error("host pull-downs wrong");
    a_host_fs_pd: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (is_host && host_fsl) |-> (term_vec == 5'h06))
        else $error("host FS/LS terminations wrong");

    // HS termination only where the line runs at high speed
    a_hsterm_only_hs: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        HS_TERMINATION_ENABLE |-> (hs_sel && opm_ok))
        else $error("HS termination outside HS setting");

    // Peripheral rows; the DM pull-down marks the OTG variants
    a_chirp_dp_up: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (is_peri && chirp_pe)
        |-> (term_vec == {1'b1, 2'h0, dmpd, 1'b0}))
        else $error("peripheral chirp wrong");
    a_fs_dp_up: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (is_peri && fs_pe && opm_ok)
        |-> (term_vec == {1'b1, 2'h0, dmpd, 1'b0}))
        else $error("peripheral FS wrong");
    a_ls_dm_up: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (!dppd && !dmpd && ls_pe && opm_ok) |-> (term_vec == 5'h08))
        else $error("peripheral LS wrong");
    a_peri_hs_term: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (is_peri && hs_sel && opm_ok)
        |-> (term_vec == {3'h0, dmpd, 1'b1}))
        else $error("peripheral HS wrong");
    a_charger_dm_pd: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        chg_det |-> (term_vec == 5'h02))
        else $error("charger detect wrong");

    // Register port and trim fields
    a_write_seen: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        wr_func |=> (func_q == $past(REG_WDATA)))
        else $error("function control write lost");
    a_trim_follow: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        wr_comp |=> (TX_AMPLITUDE_TRIM == $past(REG_WDATA[3:0])))
        else $error("amplitude trim not updated");
    a_sens_follow: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        wr_comp |=> (SQUELCH_SENSITIVITY_TRIM == $past(REG_WDATA[7:4])))
        else $error("squelch sensitivity not updated");

    // Read data may only stand in the slot after a read strobe
    a_read_slot: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !REG_RD |=> (REG_RDATA == 8'h00))
        else $error("read data outside its slot");

    // Receive side
    a_squelch_gate: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (hs_mode && sq_on) |=> !RX_VALID)
        else $error("squelched noise accepted");

    // Transmit side; a missed stuff slot corrupts every long run of ones
    sequence s_six_ones;
        (take && TX_BIT) [*6];
    endsequence
    sequence s_stuff_slot;
        (!TX_READY && stuff_now) ##1 (ones_q == 3'h0);
    endsequence
    a_stuff_after_six: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        s_six_ones |=> s_stuff_slot)
        else $error("no stuff slot after six ones");
    a_stuff_zero: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        stuff_now |=> (ones_q == 3'h0 && nrzi_q != $past(nrzi_q)))
        else $error("stuff bit missing");
    a_one_driver: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !(HS_TX_OE && FS_TX_OE))
        else $error("both transmitters enabled");

    // Drivers must let go of the line as soon as the reset pin drops
    a_reset_tristate: assert property (
        @(posedge CLK) !RESET_N |-> (!HS_TX_OE && !FS_TX_OE))
        else $error("line drivers active in reset");
endmodule // uts_usb_termination_select

// >>> uts_link_model.sv
// Link-side model: drives the register port; the bench drives the transmit bit stream.
// Assumes one clock; all requests change just after a rising edge.
`timescale 1ns/10ps
module uts_link_model (
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // Idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write; caller picks the combination written
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // uts_link_model

// >>> uts_usb_termination_select_tb.sv
// Self-checking bench for the termination select block.
// Assumes the link model above drives the register port.
`timescale 1ns/10ps
module uts_usb_termination_select_tb;
    logic       clk, reset_n, reg_wr, reg_rd, tx_valid, tx_bit, tx_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic       hs_rx, fs_rx, squelch, se_dp, se_dm, rx_bit, rx_valid;
    logic       hs_tx_data, hs_tx_oe, fs_tx_data, fs_tx_oe;
    logic       dp_pu, dm_pu, dp_pd, dm_pd, hs_term;
    logic [1:0] line_state;
    logic [3:0] amp_trim, sq_trim;
    logic [7:0] term;
    int         fails, samples_checked;
    // Order matches the package termination vector
    assign term = {3'h0, dp_pu, dm_pu, dp_pd, dm_pd, hs_term};

    uts_usb_termination_select i_uts_usb_termination_select (
        .CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .TX_VALID(tx_valid), .TX_BIT(tx_bit),
        .TX_READY(tx_ready), .HS_RX_IN(hs_rx), .FS_RX_IN(fs_rx),
        .SQUELCH_IN(squelch), .SE_DP_IN(se_dp), .SE_DM_IN(se_dm),
        .RX_BIT(rx_bit), .RX_VALID(rx_valid), .LINE_STATE(line_state),
        .HS_TX_DATA(hs_tx_data), .HS_TX_OE(hs_tx_oe),
        .FS_TX_DATA(fs_tx_data), .FS_TX_OE(fs_tx_oe),
        .DP_PULLUP_ENABLE(dp_pu), .DM_PULLUP_ENABLE(dm_pu),
        .DP_PULLDOWN_ENABLE(dp_pd), .DM_PULLDOWN_ENABLE(dm_pd),
        .HS_TERMINATION_ENABLE(hs_term), .TX_AMPLITUDE_TRIM(amp_trim),
        .SQUELCH_SENSITIVITY_TRIM(sq_trim));
    uts_link_model i_uts_link_model (
        .clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Reset values and power-up terminations
    task automatic test_reset;
        chk("term rst", term, {3'h0, uts_pkg::TERM_FALLBACK});
        i_uts_link_model.rd(uts_pkg::ADDR_FUNC_CTRL, v);
        chk("func rst", v, uts_pkg::FUNC_CTRL_RST);
        i_uts_link_model.rd(uts_pkg::ADDR_OTG_CTRL, v);
        chk("otg rst", v, uts_pkg::OTG_CTRL_RST);
        i_uts_link_model.rd(uts_pkg::ADDR_HS_COMP, v);
        chk("comp rst", v, uts_pkg::HS_COMP_RST);
        $display("done reset");
    endtask

    // Every table row plus undefined ones: {func, otg, expected}
    task automatic test_table;
        logic [23:0] rows [27] = '{
            24'h0c0600, 24'h010606, 24'h100607, 24'h000607, 24'h050606,
            24'h070606, 24'h150606, 24'h060606, 24'h160606, 24'h140010,
            24'h000001, 24'h050010, 24'h150010, 24'h060008, 24'h160008,
            24'h100001, 24'h140412, 24'h000403, 24'h050412, 24'h150412,
            24'h100403, 24'h010402, 24'h060406, 24'h030006, 24'h180606,
            24'h010006, 24'h0c0400};
        for (int i = 0; i < 27; i++) begin
            i_uts_link_model.wr(uts_pkg::ADDR_FUNC_CTRL, rows[i][23:16]);
            i_uts_link_model.wr(uts_pkg::ADDR_OTG_CTRL, rows[i][15:8]);
            #1;
            chk("term row", term, rows[i][7:0]);
        end
        $display("done table");
    endtask

    // Trim fields and an unmapped read
    task automatic test_trim;
        i_uts_link_model.wr(uts_pkg::ADDR_HS_COMP, 8'ha5);
        #1;
        chk("amp trim", {4'h0, amp_trim}, 8'h05);
        chk("sq trim", {4'h0, sq_trim}, 8'h0a);
        i_uts_link_model.rd(uts_pkg::ADDR_HS_COMP, v);
        chk("comp rd", v, 8'ha5);
        i_uts_link_model.rd(8'h77, v);
        chk("unmapped", v, 8'h00);
        $display("done trim");
    endtask

    // Receiver selection, squelch and line state; sync delay margin
    task automatic test_rx;
        i_uts_link_model.wr(uts_pkg::ADDR_FUNC_CTRL, 8'h00);
        @(posedge clk);
        hs_rx   <= 1'b1;
        fs_rx   <= 1'b0;
        squelch <= 1'b0;
        se_dp   <= 1'b1;
        se_dm   <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk("rx hs", {7'h0, rx_bit}, 8'h01);
        chk("rx val", {7'h0, rx_valid}, 8'h01);
        chk("line", {6'h0, line_state}, 8'h01);
        i_uts_link_model.rd(uts_pkg::ADDR_STATUS, v);
        chk("status", v, 8'h0d);
        @(posedge clk);
        squelch <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk("squelch", {7'h0, rx_valid}, 8'h00);
        i_uts_link_model.wr(uts_pkg::ADDR_FUNC_CTRL, 8'h05);
        repeat (8) @(posedge clk);
        #1;
        chk("rx fs", {7'h0, rx_bit}, 8'h00);
        chk("fs val", {7'h0, rx_valid}, 8'h01);
        $display("done rx");
    endtask

    // Six ones accepted, then a stuff cycle refuses the next bit
    task automatic test_tx;
        int taken;
        logic line;
        taken = 0;
        i_uts_link_model.wr(uts_pkg::ADDR_FUNC_CTRL, 8'h00);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_bit   <= 1'b1;
        #1;
        for (int i = 0; i < 20; i++) begin
            if (tx_ready !== 1'b1)
                break;
            taken++;
            @(posedge clk);
            #1;
        end
        chk("stuff", taken[7:0], {5'h0, uts_pkg::STUFF_LIMIT});
        chk("hs oe", {7'h0, hs_tx_oe}, 8'h01);
        chk("fs oe", {7'h0, fs_tx_oe}, 8'h00);
        line = hs_tx_data;
        @(posedge clk);
        #1;
        chk("stuff bit", {7'h0, hs_tx_data}, {7'h0, !line});
        chk("fs line", {7'h0, fs_tx_data}, {7'h0, !line});
        chk("stuff oe", {7'h0, hs_tx_oe}, 8'h01);
        chk("ready back", {7'h0, tx_ready}, 8'h01);
        $display("done tx");
    endtask

    // Reset in mid-transmit drops both drivers at once
    task automatic test_reset_oe;
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        chk("hs oe rst", {7'h0, hs_tx_oe}, 8'h00);
        chk("fs oe rst", {7'h0, fs_tx_oe}, 8'h00);
        @(posedge clk);
        tx_valid <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("term rst2", term, {3'h0, uts_pkg::TERM_FALLBACK});
        $display("done reset oe");
    endtask

    initial begin
        fails = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        tx_valid = 1'b0;
        tx_bit = 1'b0;
        hs_rx = 1'b0;
        fs_rx = 1'b1;
        squelch = 1'b1;
        se_dp = 1'b0;
        se_dm = 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        test_reset;
        test_table;
        test_trim;
        test_rx;
        test_tx;
        test_reset_oe;
        end_of_test;
    end
endmodule // uts_usb_termination_select_tb
